// ### hdl/msp_pkg.sv
// msp_pkg: constants, encodings and helpers for the monitor slave port.
// assumes both link ends and the bench import it; no logic lives here.
package msp_pkg;
   // ==========================================================
   // clock and timing
   localparam int MSP_CLK_PERIOD_NS = 100;
   localparam int MSP_SCL_PERIOD_NS = 800;
   localparam int MSP_QUARTER_CYCLES = MSP_SCL_PERIOD_NS / (4 * MSP_CLK_PERIOD_NS);
   localparam int MSP_STUCK_MS = 33;
   localparam int MSP_STUCK_CYCLES = MSP_STUCK_MS * 1000000 / MSP_CLK_PERIOD_NS;
   localparam int MSP_STUCK_W = 20;
   // ==========================================================
   // addressing
   localparam logic [2:0] MSP_ADDR_HIGH = 3'h6;
   localparam logic [6:0] MSP_MASS_WRITE_ADDR = 7'h66;
   localparam logic [6:0] MSP_ARA_ADDR = 7'h0c;
   localparam logic [1:0] MSP_PIN_L = 2'h0;
   localparam logic [1:0] MSP_PIN_H = 2'h1;
   localparam logic [1:0] MSP_PIN_NC = 2'h2;
   localparam logic [3:0] MSP_SEL_RESET = 4'hf;
   // ==========================================================
   // register pointer and special registers
   localparam logic [6:0] MSP_PTR_LAST = 7'h43;
   localparam logic [6:0] MSP_PTR_ZERO = 7'h00;
   localparam logic [7:0] MSP_MAKER_ID_A = 8'he7;
   localparam logic [7:0] MSP_MAKER_ID_B = 8'he8;
   localparam logic [7:0] MSP_IDLE_BYTE = 8'hff;
   localparam logic [6:0] MSP_REG_CTRL_B = 7'h01;
   localparam logic [6:0] MSP_REG_ALERT_A = 7'h02;
   localparam logic [6:0] MSP_REG_ALERT_B = 7'h03;
   localparam int MSP_RELEASE_BIT = 7;
   localparam logic [3:0] MSP_BYTE_BITS = 4'h8;
   // ==========================================================
   // host command port
   localparam logic [31:0] MSP_HOST_CMD = 32'h0000_0000;
   localparam logic [31:0] MSP_HOST_STATUS = 32'h0000_0004;
   localparam logic [1:0] MSP_OP_START = 2'h1;
   localparam logic [1:0] MSP_OP_STOP = 2'h2;
   localparam logic [1:0] MSP_OP_BYTE = 2'h3;
   localparam int MSP_CMD_OP_LSB = 8;
   localparam int MSP_CMD_READ = 10;
   localparam int MSP_CMD_NACK = 11;

   // lower address nibble from the two three-state select pins
   function automatic logic [3:0] msp_sel_decode(input logic [1:0] hi, input logic [1:0] lo);
      logic [3:0] v;
      v = 4'hf;
      case ({hi, lo})
         {MSP_PIN_H, MSP_PIN_L}: v = 4'h7;
         {MSP_PIN_NC, MSP_PIN_H}: v = 4'h8;
         {MSP_PIN_H, MSP_PIN_H}: v = 4'h9;
         {MSP_PIN_NC, MSP_PIN_NC}: v = 4'ha;
         {MSP_PIN_NC, MSP_PIN_L}: v = 4'hb;
         {MSP_PIN_L, MSP_PIN_H}: v = 4'hc;
         {MSP_PIN_H, MSP_PIN_NC}: v = 4'hd;
         {MSP_PIN_L, MSP_PIN_NC}: v = 4'he;
         default: v = 4'hf;
      endcase
      return v;
   endfunction

   // pointer advance with wrap after the last register
   function automatic logic [6:0] msp_ptr_inc(input logic [6:0] p);
      return (p == MSP_PTR_LAST) ? MSP_PTR_ZERO : p + 7'h01;
   endfunction
endpackage

// ### hdl/msp_link_if.sv
// msp_link_if: the serial link between bus master and monitor slave.
// assumes open-drain data; the wired level is resolved here from the enables.
`timescale 1ns/1ps
interface msp_link_if;
   logic scl;
   logic mst_sda_o;
   logic mst_sda_oe;
   logic serial_data_pulldown_pin;
   logic sda;
   // ==========================================================
   // wired-and data line, tied input and pulldown output of the slave
   assign sda = ~serial_data_pulldown_pin & ~(mst_sda_oe & ~mst_sda_o);
   modport dev (input scl, input sda, output serial_data_pulldown_pin);
   modport mst (output scl, output mst_sda_o, output mst_sda_oe, input sda);
endinterface

// ### hdl/msp_slave.sv
// msp_slave: serial slave port of the monitor with alert response handling.
// assumes scl, data and select pins are asynchronous to hclk.
`timescale 1ns/1ps
module msp_slave #(
   parameter int STUCK_CYCLES = msp_pkg::MSP_STUCK_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   msp_link_if.dev link,
   input wire logic [1:0] addr_select_pin_hi,
   input wire logic [1:0] addr_select_pin_lo,
   input wire logic shutdown_req,
   input wire logic multipurpose_pin_three_is_alert,
   input wire logic [7:0] latched_fault_group_a,
   input wire logic [7:0] latched_fault_group_b,
   input wire logic [7:0] reg_rdata,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic multipurpose_pin_three_pull,
   output logic [6:0] own_addr
);
   import msp_pkg::*;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_RX = 6'h04,
      ST_ACK = 6'h08,
      ST_TX = 6'h10,
      ST_TXACK = 6'h20
   } msp_state_e;

   msp_state_e state_r;
   logic scl_q1, scl_q2, scl_q3, sda_q1, sda_q2, sda_q3;
   logic [3:0] pins_q1, pins_q2;
   logic [3:0] sel_r;
   logic [MSP_STUCK_W-1:0] stuck_r;
   logic [3:0] cnt_r;
   logic [7:0] sh_r;
   logic [6:0] ptr_r;
   logic pull_r, rd_mode_r, ara_r, cmd_next_r, inc_pend_r, more_r;
   logic id_sel_r, id_used_r;
   logic [7:0] id_cmd_r;
   logic [7:0] ctrl_r, en_a_r, en_b_r;
   logic [15:0] acked_r;
   logic alert_r, reg_wr_r, reg_rd_r;
   logic [7:0] reg_addr_r, reg_wdata_r;

   // ==========================================================
   // pin synchronisers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_q1 <= 1'b1;
         scl_q2 <= 1'b1;
         scl_q3 <= 1'b1;
         sda_q1 <= 1'b1;
         sda_q2 <= 1'b1;
         sda_q3 <= 1'b1;
         pins_q1 <= 4'h0;
         pins_q2 <= 4'h0;
      end else begin
         scl_q1 <= link.scl;
         scl_q2 <= scl_q1;
         scl_q3 <= scl_q2;
         sda_q1 <= link.sda;
         sda_q2 <= sda_q1;
         sda_q3 <= sda_q2;
         pins_q1 <= {addr_select_pin_hi, addr_select_pin_lo};
         pins_q2 <= pins_q1;
      end
   end

   // ==========================================================
   // bus events and decode
   wire scl_rise = scl_q2 & ~scl_q3;
   wire scl_fall = ~scl_q2 & scl_q3;
   wire start_det = scl_q2 & scl_q3 & ~sda_q2 & sda_q3;
   wire stop_det = scl_q2 & scl_q3 & sda_q2 & ~sda_q3;
   wire byte_done = scl_fall & (cnt_r == MSP_BYTE_BITS);
   wire [6:0] my_addr = {MSP_ADDR_HIGH, sel_r};
   wire own_hit = sh_r[7:1] == my_addr;
   wire mass_hit = (sh_r[7:1] == MSP_MASS_WRITE_ADDR) & ~sh_r[0];
   wire ara_hit = (sh_r[7:1] == MSP_ARA_ADDR) & sh_r[0] & alert_r;
   wire addr_hit = own_hit | mass_hit | ara_hit;
   wire is_id_cmd = (sh_r == MSP_MAKER_ID_A) | (sh_r == MSP_MAKER_ID_B);
   wire stuck_hit = stuck_r == STUCK_CYCLES[MSP_STUCK_W-1:0];
   wire [15:0] pend = {latched_fault_group_b & en_b_r, latched_fault_group_a & en_a_r};
   wire release_evt = (state_r == ST_ADDR) & byte_done &
                      (ara_hit | (own_hit & ctrl_r[MSP_RELEASE_BIT]));
   wire own_sel = (ptr_r == MSP_REG_CTRL_B) | (ptr_r == MSP_REG_ALERT_A) |
                  (ptr_r == MSP_REG_ALERT_B);
   wire [7:0] own_val = (ptr_r == MSP_REG_CTRL_B) ? ctrl_r :
                        (ptr_r == MSP_REG_ALERT_A) ? en_a_r : en_b_r;
   // next byte to send: own address for an alert response, idle byte once the id byte is sent, else register data
   wire [7:0] tx_byte = ara_r ? {my_addr, 1'b0} :
                        (id_sel_r & id_used_r) ? MSP_IDLE_BYTE :
                        (own_sel & ~id_sel_r) ? own_val : reg_rdata;

   // ==========================================================
   // select address, frozen during shutdown
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_r <= MSP_SEL_RESET;
      end else if (!shutdown_req) begin
         sel_r <= msp_sel_decode(pins_q2[3:2], pins_q2[1:0]);
      end
   end

   // ==========================================================
   // stuck-bus timer, saturating
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stuck_r <= '0;
      end else if (scl_q2 & sda_q2) begin
         stuck_r <= '0;
      end else if (!stuck_hit) begin
         stuck_r <= stuck_r + 1'b1;
      end
   end

   // ==========================================================
   // alert generation with re-arm on new or recurring fault
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acked_r <= 16'h0000;
         alert_r <= 1'b0;
      end else begin
         acked_r <= release_evt ? pend : (acked_r & pend);
         alert_r <= ~release_evt & multipurpose_pin_three_is_alert &
                    (|(pend & ~acked_r));
      end
   end

   // ==========================================================
   // byte engine
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= ST_IDLE;
         cnt_r <= 4'h0;
         sh_r <= 8'h00;
         ptr_r <= MSP_PTR_ZERO;
         pull_r <= 1'b0;
         rd_mode_r <= 1'b0;
         ara_r <= 1'b0;
         cmd_next_r <= 1'b0;
         inc_pend_r <= 1'b0;
         more_r <= 1'b0;
         id_sel_r <= 1'b0;
         id_used_r <= 1'b0;
         id_cmd_r <= 8'h00;
         ctrl_r <= 8'h00;
         en_a_r <= 8'h00;
         en_b_r <= 8'h00;
         reg_wr_r <= 1'b0;
         reg_rd_r <= 1'b0;
         reg_wdata_r <= 8'h00;
      end else begin
         reg_wr_r <= 1'b0;
         reg_rd_r <= 1'b0;
         if (stuck_hit) begin
            // a stuck bus can swallow the stop, so the pointer is cleared here too
            state_r <= ST_IDLE;
            pull_r <= 1'b0;
            ptr_r <= MSP_PTR_ZERO;
            id_sel_r <= 1'b0;
            inc_pend_r <= 1'b0;
         end else if (stop_det) begin
            state_r <= ST_IDLE;
            ptr_r <= MSP_PTR_ZERO;
            pull_r <= 1'b0;
            id_sel_r <= 1'b0;
            inc_pend_r <= 1'b0;
         end else if (start_det) begin
            state_r <= ST_ADDR;
            cnt_r <= 4'h0;
            pull_r <= 1'b0;
         end else begin
            case (state_r)
               ST_ADDR, ST_RX: begin
                  if (scl_rise) begin
                     sh_r <= {sh_r[6:0], sda_q2};
                     cnt_r <= cnt_r + 4'h1;
                  end else if (byte_done && state_r == ST_ADDR) begin
                     if (addr_hit) begin
                        pull_r <= 1'b1;
                        state_r <= ST_ACK;
                        rd_mode_r <= sh_r[0];
                        ara_r <= ara_hit;
                        cmd_next_r <= ~sh_r[0];
                     end else begin
                        state_r <= ST_IDLE;
                     end
                  end else if (byte_done) begin
                     pull_r <= 1'b1;
                     state_r <= ST_ACK;
                     if (cmd_next_r) begin
                        cmd_next_r <= 1'b0;
                        ptr_r <= {1'b0, sh_r[5:0]};
                        id_sel_r <= is_id_cmd;
                        id_used_r <= 1'b0;
                        id_cmd_r <= sh_r;
                     end else if (!id_sel_r) begin
                        reg_wr_r <= ~own_sel;
                        reg_wdata_r <= sh_r;
                        inc_pend_r <= 1'b1;
                        if (ptr_r == MSP_REG_CTRL_B) ctrl_r <= sh_r;
                        if (ptr_r == MSP_REG_ALERT_A) en_a_r <= sh_r;
                        if (ptr_r == MSP_REG_ALERT_B) en_b_r <= sh_r;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     cnt_r <= 4'h0;
                     if (inc_pend_r) ptr_r <= msp_ptr_inc(ptr_r);
                     inc_pend_r <= 1'b0;
                     if (rd_mode_r) begin
                        state_r <= ST_TX;
                        sh_r <= tx_byte;
                        pull_r <= ~tx_byte[7];
                        reg_rd_r <= ~ara_r;
                     end else begin
                        state_r <= ST_RX;
                        pull_r <= 1'b0;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (cnt_r == MSP_BYTE_BITS - 4'h1) begin
                        pull_r <= 1'b0;
                        state_r <= ST_TXACK;
                     end else begin
                        pull_r <= ~sh_r[6];
                        sh_r <= {sh_r[6:0], 1'b1};
                        cnt_r <= cnt_r + 4'h1;
                     end
                  end
               end
               ST_TXACK: begin
                  if (scl_rise) begin
                     more_r <= ~sda_q2;
                     if (id_sel_r) id_used_r <= 1'b1;
                     else if (!ara_r) ptr_r <= msp_ptr_inc(ptr_r);
                  end else if (scl_fall) begin
                     cnt_r <= 4'h0;
                     if (more_r) begin
                        state_r <= ST_TX;
                        sh_r <= tx_byte;
                        pull_r <= ~tx_byte[7];
                        reg_rd_r <= ~ara_r;
                     end else begin
                        state_r <= ST_IDLE;
                     end
                  end
               end
               default: pull_r <= 1'b0;
            endcase
         end
      end
   end

   // ==========================================================
   // registered user-side outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reg_addr_r <= 8'h00;
      end else begin
         reg_addr_r <= id_sel_r ? id_cmd_r : {1'b0, ptr_r};
      end
   end

   assign link.serial_data_pulldown_pin = pull_r;
   assign reg_addr = reg_addr_r;
   assign reg_wdata = reg_wdata_r;
   assign reg_wr = reg_wr_r;
   assign reg_rd = reg_rd_r;
   assign multipurpose_pin_three_pull = alert_r;
   assign own_addr = {MSP_ADDR_HIGH, sel_r};
endmodule

// ### hdl/msp_master.sv
// msp_master: byte-level serial bus master steered over AHB-Lite.
// assumes a single AHB-Lite master and the slave on the link interface.
`timescale 1ns/1ps
module msp_master (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   msp_link_if.mst link
);
   import msp_pkg::*;

   typedef enum logic [3:0] {
      HS_IDLE = 4'h1,
      HS_START = 4'h2,
      HS_STOP = 4'h4,
      HS_BIT = 4'h8
   } msp_hstate_e;

   msp_hstate_e state_r;
   logic [1:0] step_r;
   logic [7:0] q_r;
   logic [3:0] bit_r;
   logic [8:0] tx_r, rx_r;
   logic scl_r, oe_r, sda_q1, sda_q2;
   logic wr_pend_r, cmd_pend_r;
   logic [31:0] hrdata_r;

   // ==========================================================
   // bus decode
   wire take = hsel & htrans[1] & hready;
   wire busy = state_r != HS_IDLE;
   wire tick = q_r == MSP_QUARTER_CYCLES[7:0] - 8'h01;
   wire [1:0] op = hwdata[MSP_CMD_OP_LSB +: 2];
   wire cmd_go = wr_pend_r & cmd_pend_r & ~busy;
   wire [31:0] status = {16'h0000, rx_r[8:1], 6'h00, ~rx_r[0], busy};

   // ==========================================================
   // ahb-lite slave, zero wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         cmd_pend_r <= 1'b0;
         hrdata_r <= 32'h0000_0000;
      end else begin
         wr_pend_r <= take & hwrite;
         cmd_pend_r <= haddr == MSP_HOST_CMD;
         hrdata_r <= (take & ~hwrite & (haddr == MSP_HOST_STATUS)) ? status : 32'h0000_0000;
      end
   end

   // ==========================================================
   // data sample synchroniser
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sda_q1 <= 1'b1;
         sda_q2 <= 1'b1;
      end else begin
         sda_q1 <= link.sda;
         sda_q2 <= sda_q1;
      end
   end

   // ==========================================================
   // sequencer: four quarter steps per bit, start or stop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= HS_IDLE;
         step_r <= 2'h0;
         q_r <= 8'h00;
         bit_r <= 4'h0;
         tx_r <= 9'h1ff;
         rx_r <= 9'h1ff;
         scl_r <= 1'b1;
         oe_r <= 1'b0;
      end else if (cmd_go) begin
         step_r <= 2'h0;
         q_r <= 8'h00;
         bit_r <= 4'h0;
         tx_r <= hwdata[MSP_CMD_READ] ? {MSP_IDLE_BYTE, hwdata[MSP_CMD_NACK]}
                                      : {hwdata[7:0], 1'b1};
         if (op == MSP_OP_START) state_r <= HS_START;
         else if (op == MSP_OP_STOP) state_r <= HS_STOP;
         else if (op == MSP_OP_BYTE) state_r <= HS_BIT;
      end else if (busy) begin
         q_r <= tick ? 8'h00 : q_r + 8'h01;
         if (tick) begin
            step_r <= step_r + 2'h1;
            case (state_r)
               HS_START: begin
                  if (step_r == 2'h0) begin
                     oe_r <= 1'b0;
                     scl_r <= 1'b0;
                  end
                  if (step_r == 2'h1) scl_r <= 1'b1;
                  if (step_r == 2'h2) oe_r <= 1'b1;
                  if (step_r == 2'h3) begin
                     scl_r <= 1'b0;
                     state_r <= HS_IDLE;
                  end
               end
               HS_STOP: begin
                  if (step_r == 2'h0) begin
                     oe_r <= 1'b1;
                     scl_r <= 1'b0;
                  end
                  if (step_r == 2'h1) scl_r <= 1'b1;
                  if (step_r == 2'h2) oe_r <= 1'b0;
                  if (step_r == 2'h3) state_r <= HS_IDLE;
               end
               HS_BIT: begin
                  if (step_r == 2'h0) oe_r <= ~tx_r[8];
                  if (step_r == 2'h1) scl_r <= 1'b1;
                  if (step_r == 2'h2) rx_r <= {rx_r[7:0], sda_q2};
                  if (step_r == 2'h3) begin
                     scl_r <= 1'b0;
                     tx_r <= {tx_r[7:0], 1'b1};
                     bit_r <= bit_r + 4'h1;
                     if (bit_r == MSP_BYTE_BITS) state_r <= HS_IDLE;
                  end
               end
               default: state_r <= HS_IDLE;
            endcase
         end
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;
   assign link.scl = scl_r;
   assign link.mst_sda_oe = oe_r;
   assign link.mst_sda_o = 1'b0;
endmodule

// ### tb/msp_link_props.sv
// msp_link_props: assertions on the serial link between the two ends.
// assumes plain inputs wired from the link interface and the host clock.
`timescale 1ns/1ps
module msp_link_props #(
   parameter int STUCK_CYCLES = 400
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic scl,
   input wire logic mst_sda_oe,
   input wire logic serial_data_pulldown_pin,
   input wire logic sda
);
   // ==========================================================
   // run length of a low clock or data line
   int low_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         low_r <= 0;
      else
         low_r <= (scl && sda) ? 0 : low_r + 1;
   end
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // ==========================================================
   // wire timing of both ends
   a_pull_scl_low: assert property ($changed(serial_data_pulldown_pin) |-> !scl)
      else $error("pulldown moved with clock high");
   a_pull_stands: assert property ($rose(scl) |-> $stable(serial_data_pulldown_pin)[*4])
      else $error("pulldown moved during high clock");
   a_pull_after_fall: assert property ($rose(serial_data_pulldown_pin) |-> !$past(scl, 2))
      else $error("pulldown too soon after fall");
   a_scl_high_len: assert property ($rose(scl) |-> scl[*4])
      else $error("clock high too short");
   a_scl_low_len: assert property ($fell(scl) |-> (!scl)[*2])
      else $error("clock low too short");
   a_start_by_master: assert property ($fell(sda) && scl |-> $rose(mst_sda_oe))
      else $error("start not made by master");
   a_stop_by_master: assert property ($rose(sda) && scl |-> $fell(mst_sda_oe))
      else $error("stop not made by master");
   a_stuck_release: assert property ((low_r > STUCK_CYCLES + 8) |-> !serial_data_pulldown_pin)
      else $error("stuck bus not released");
   cover property ($rose(serial_data_pulldown_pin));
   cover property (low_r > STUCK_CYCLES);
   cover property ($rose(sda) && scl);
endmodule

// ### tb/msp_slave_tb.sv
// msp_slave_tb: drives the master over AHB-Lite, checks the slave user side.
// assumes both link ends meet on one interface; 10 MHz host clock.
`timescale 1ns/1ps
module msp_slave_tb;
   import msp_pkg::*;
   localparam int STK = 400;
   localparam logic [6:0] ME = 7'h6f;
   localparam logic [3:0] PINS [9] = '{4'h4, 4'h9, 4'h5, 4'ha, 4'h8, 4'h1, 4'h6, 4'h2, 4'h0};
   localparam logic [7:0] BAD [3] = '{8'hcd, 8'ha0, 8'h19};
   logic hclk = 0, hresetn = 0, hwrite = 0, shutdown_req = 0, got_v = 0;
   logic hreadyout, hresp, reg_wr, reg_rd, pull;
   logic [1:0] htrans = 2'h0;
   logic [3:0] pins = 4'h4;
   logic [6:0] own_addr;
   logic [7:0] fault_a = 8'h00, got = 8'h00, p, reg_addr, reg_wdata;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rnd = 32'h0001_4ec4, s, hrdata;
   logic [15:0] wq[$], rq[$];
   int fail_count = 0, n_tests = 0;
   msp_link_if link();
   msp_master u_msp_master (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(link));
   msp_slave #(.STUCK_CYCLES(STK)) u_msp_slave (.hclk(hclk), .hresetn(hresetn), .link(link),
      .addr_select_pin_hi(pins[3:2]), .addr_select_pin_lo(pins[1:0]),
      .shutdown_req(shutdown_req), .multipurpose_pin_three_is_alert(1'b1),
      .latched_fault_group_a(fault_a), .latched_fault_group_b(8'h00),
      .reg_rdata(reg_addr ^ 8'h5a), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .multipurpose_pin_three_pull(pull), .own_addr(own_addr));
   msp_link_props #(.STUCK_CYCLES(STK)) u_msp_link_props (.hclk(hclk), .hresetn(hresetn),
      .scl(link.scl), .mst_sda_oe(link.mst_sda_oe),
      .serial_data_pulldown_pin(link.serial_data_pulldown_pin), .sda(link.sda));
   initial begin
      forever #50 hclk = ~hclk;
   end
   // ==========================================================
   // checks, bus cycles and link operations
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a);
      @(posedge hclk);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= s;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      s = hrdata;
   endtask
   task automatic op(input logic [31:0] c);
      s = c;
      ahb(1'b1, MSP_HOST_CMD);
      do ahb(1'b0, MSP_HOST_STATUS); while (s[0] !== 1'b0);
   endtask
   task automatic tx(input logic [7:0] b, input logic ack);
      op({22'h0, MSP_OP_BYTE, b});
      chk({15'h0, s[1]}, {15'h0, ack});
   endtask
   task automatic rx(input logic nak, input logic [7:0] e);
      rq.push_back({8'h00, e});
      op({20'h0, nak, 1'b1, MSP_OP_BYTE, 8'hff});
      got <= s[15:8];
      got_v <= 1'b1;
      @(posedge hclk);
      got_v <= 1'b0;
   endtask
   task automatic wreg(input logic [6:0] r, input logic [7:0] v);
      op({22'h0, MSP_OP_START, 8'h00});
      tx({ME, 1'b0}, 1'b1);
      tx({1'b0, r}, 1'b1);
      tx(v, 1'b1);
      op({22'h0, MSP_OP_STOP, 8'h00});
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // register writes and read bytes are matched against the oldest note
   always @(posedge hclk) begin
      if (reg_wr === 1'b1)
         chk({reg_addr, reg_wdata}, wq.size() > 0 ? wq.pop_front() : 16'hxxxx);
      if (got_v)
         chk({8'h00, got}, rq.size() > 0 ? rq.pop_front() : 16'hxxxx);
   end
   initial begin
      repeat (60000) @(posedge hclk);
      fail_count++;
      end_sim();
   end
   // ==========================================================
   // test sequence
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      chk({15'h0, pull}, 16'h0);
      for (int i = 0; i < 9; i++) begin
         pins <= PINS[i];
         repeat (6) @(posedge hclk);
         chk({9'h0, own_addr}, {9'h0, MSP_ADDR_HIGH, 4'h7 + 4'(i)});
      end
      shutdown_req <= 1'b1;
      repeat (4) @(posedge hclk);
      pins <= 4'h4;
      repeat (6) @(posedge hclk);
      chk({9'h0, own_addr}, {9'h0, ME});
      pins <= 4'h0;
      shutdown_req <= 1'b0;
      $display("test address select done");
      p = 8'h3f;
      wq.push_back({8'h3f, 8'h00});
      wreg(7'h3f, 8'h00);
      $display("test single write done");
      op({22'h0, MSP_OP_START, 8'h00});
      tx({ME, 1'b0}, 1'b1);
      tx(8'hff, 1'b1);
      repeat (6) begin
         rnd = nxt(rnd);
         wq.push_back({p, rnd[7:0]});
         tx(rnd[7:0], 1'b1);
         p = (p == 8'h43) ? 8'h00 : p + 8'h01;
      end
      op({22'h0, MSP_OP_STOP, 8'h00});
      $display("test extended write done");
      op({22'h0, MSP_OP_START, 8'h00});
      tx({ME, 1'b0}, 1'b1);
      tx(8'h3f, 1'b1);
      op({22'h0, MSP_OP_START, 8'h00});
      tx({ME, 1'b1}, 1'b1);
      rx(1'b0, 8'h3f ^ 8'h5a);
      rx(1'b0, 8'h40 ^ 8'h5a);
      repeat (4) @(posedge hclk);
      chk({15'h0, link.serial_data_pulldown_pin}, 16'h1);
      repeat (STK + 80) @(posedge hclk);
      chk({15'h0, link.serial_data_pulldown_pin}, 16'h0);
      op({22'h0, MSP_OP_STOP, 8'h00});
      op({22'h0, MSP_OP_START, 8'h00});
      tx({ME, 1'b1}, 1'b1);
      rx(1'b1, 8'h00 ^ 8'h5a);
      op({22'h0, MSP_OP_STOP, 8'h00});
      $display("test read and stuck bus done");
      rnd = nxt(rnd);
      wq.push_back({8'h05, rnd[7:0]});
      wreg(7'h05, rnd[7:0]);
      op({22'h0, MSP_OP_START, 8'h00});
      tx({MSP_MASS_WRITE_ADDR, 1'b0}, 1'b1);
      tx(8'h06, 1'b1);
      wq.push_back({8'h06, rnd[15:8]});
      tx(rnd[15:8], 1'b1);
      op({22'h0, MSP_OP_STOP, 8'h00});
      foreach (BAD[i]) begin
         op({22'h0, MSP_OP_START, 8'h00});
         tx(BAD[i], 1'b0);
         op({22'h0, MSP_OP_STOP, 8'h00});
      end
      op({22'h0, MSP_OP_START, 8'h00});
      tx({ME, 1'b0}, 1'b1);
      tx(MSP_MAKER_ID_A, 1'b1);
      op({22'h0, MSP_OP_START, 8'h00});
      tx({ME, 1'b1}, 1'b1);
      rx(1'b0, MSP_MAKER_ID_A ^ 8'h5a);
      rx(1'b1, MSP_IDLE_BYTE);
      op({22'h0, MSP_OP_STOP, 8'h00});
      $display("test addressing and id done");
      wreg(MSP_REG_ALERT_A, 8'h01);
      fault_a <= 8'h01;
      repeat (8) @(posedge hclk);
      chk({15'h0, pull}, 16'h1);
      op({22'h0, MSP_OP_START, 8'h00});
      tx({MSP_ARA_ADDR, 1'b1}, 1'b1);
      rx(1'b1, {ME, 1'b0});
      op({22'h0, MSP_OP_STOP, 8'h00});
      chk({15'h0, pull}, 16'h0);
      fault_a <= 8'h00;
      repeat (8) @(posedge hclk);
      fault_a <= 8'h01;
      repeat (8) @(posedge hclk);
      chk({15'h0, pull}, 16'h1);
      wreg(MSP_REG_CTRL_B, 8'h80);
      wreg(MSP_REG_CTRL_B, 8'h80);
      chk({15'h0, pull}, 16'h0);
      $display("test alert done");
      chk(16'(wq.size() + rq.size()), 16'h0);
      end_sim();
   end
endmodule
